// File: rtl/ldma_pkg.sv
// Constants, types and carriers of the linked descriptor DMA engine
package ldma_pkg;
  localparam int NCH = 16;
  localparam int NPACE = 32;
  localparam int FIFO_DEPTH = 32;
  localparam int DESC_WORDS = 8;
  localparam logic [3:0] LITE_FIRST = 4'h7;
  localparam logic [3:0] LITE_LAST = 4'ha;
  localparam logic [3:0] WIDE_FIRST = 4'hb;
  localparam logic [3:0] WIDE_LAST = 4'he;
  localparam logic [3:0] LAST_CH = 4'hf;
  localparam logic [31:0] CH_BASE = 32'h7e00_7000;
  localparam logic [31:0] CH_SPACING = 32'h0000_0100;
  localparam logic [31:0] LAST_CH_BASE = 32'h7ee0_5000;
  // Descriptor word positions
  localparam logic [2:0] W_INFO = 3'h0;
  localparam logic [2:0] W_SRC = 3'h1;
  localparam logic [2:0] W_DST = 3'h2;
  localparam logic [2:0] W_CNT = 3'h3;
  localparam logic [2:0] W_STEP = 3'h4;
  localparam logic [2:0] W_NEXT = 3'h5;
  localparam logic [2:0] WW_WIDE_READ_INFO = 3'h2;
  localparam logic [2:0] WW_DST = 3'h3;
  localparam logic [2:0] WW_DSTI = 3'h4;
  localparam logic [2:0] WW_CNT = 3'h5;
  localparam logic [2:0] WW_NEXT = 3'h6;
  localparam logic [2:0] W_LAST = 3'h7;
  // Transfer info and control fields
  localparam int INFO_WIDE_WR = 5;
  localparam int INFO_BURST_LSB = 12;
  localparam int INFO_PREFETCH = 26;
  localparam int INFO_BUS_LSB = 27;
  localparam int CTRL_ACTIVE = 0;
  localparam int CTRL_PAUSE = 1;
  localparam logic [4:0] DESC_BEATS = 5'h08;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] NULL_PTR = 32'h0000_0000;

  typedef enum logic [1:0] {
    SEL_DESC = 2'h0,
    SEL_CTRL = 2'h1,
    SEL_NEXT = 2'h2,
    SEL_PACE = 2'h3
  } ldma_sel_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FREQ = 3'b001,
    ST_FDAT = 3'b011,
    ST_XRD = 3'b010,
    ST_XDAT = 3'b110,
    ST_XWR = 3'b111,
    ST_DONE = 3'b101
  } ldma_state_e;

  typedef struct packed {
    logic [31:0] addr;
    logic [4:0] beats;
    logic prio;
  } ldma_rd_req_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    logic pair;
    logic last;
    logic prio;
  } ldma_wr_req_s;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] desc_addr;
    logic [31:0] info;
    logic [31:0] src;
    logic [31:0] aux;
    logic [31:0] dst;
    logic [31:0] step;
    logic [31:0] count;
    logic [31:0] next;
    logic active;
    logic paused;
  } ldma_view_s;
endpackage : ldma_pkg

// File: rtl/ldma_top.sv
// Linked descriptor DMA engine and its staging FIFO
`timescale 1ns/1ps

// ----------------------------------------
// Staging FIFO
// ----------------------------------------
module ldma_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ldma_fifo

// ----------------------------------------
// Engine
// ----------------------------------------
module ldma_top import ldma_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NCH-1:0] chan_enable,
  input wire logic sw_wr_en,
  input wire ldma_sel_e sw_wr_sel,
  input wire logic [3:0] sw_wr_chan,
  input wire logic [31:0] sw_wr_data,
  input wire logic [3:0] sw_rd_chan,
  output ldma_view_s sw_rd_view,
  input wire logic [NPACE-1:0] pace_req_pin,
  input wire logic [NPACE-1:0] urgent_pin,
  output logic mrd_valid,
  output ldma_rd_req_s mrd_req,
  input wire logic mrd_ready,
  input wire logic rdat_valid,
  input wire logic [31:0] rdat_data,
  output logic rdat_ready,
  output logic mwr_valid,
  output ldma_wr_req_s mwr_req,
  input wire logic mwr_ready,
  output logic [1:0] bus_id
);
  // ----------------------------------------
  // Channel state
  // ----------------------------------------
  logic [31:0] desc_r [NCH];
  logic [31:0] info_r [NCH];
  logic [31:0] src_r [NCH];
  logic [31:0] aux_r [NCH];
  logic [31:0] dst_r [NCH];
  logic [31:0] step_r [NCH];
  logic [31:0] cnt_r [NCH];
  logic [31:0] next_r [NCH];
  logic [4:0] pmap_r [NCH];
  logic [NCH-1:0] active_r;
  logic [NCH-1:0] pause_r;
  logic [NCH-1:0] fetch_r;
  logic [NCH-1:0] elig;
  logic [NPACE-1:0] pace_s1_r;
  logic [NPACE-1:0] pace_s2_r;
  logic [NPACE-1:0] urg_s1_r;
  logic [NPACE-1:0] urg_s2_r;
  ldma_state_e st_r;
  ldma_state_e st_nxt;
  logic [3:0] cur_r;
  logic [3:0] last_r;
  logic [3:0] pick;
  logic any_elig;
  logic [2:0] beat_r;
  logic [4:0] nb_r;
  logic [4:0] got_r;
  logic [4:0] sent_r;
  logic pair_r;
  ldma_view_s view_r;

  function automatic logic is_lite(input logic [3:0] c);
    return c >= LITE_FIRST && c <= LITE_LAST;
  endfunction : is_lite

  function automatic logic is_wide(input logic [3:0] c);
    return c >= WIDE_FIRST && c <= WIDE_LAST;
  endfunction : is_wide

  // Pins come from other clock domains
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pace_s1_r <= '0;
      pace_s2_r <= '0;
      urg_s1_r <= '0;
      urg_s2_r <= '0;
    end else begin
      pace_s1_r <= pace_req_pin;
      pace_s2_r <= pace_s1_r;
      urg_s1_r <= urgent_pin;
      urg_s2_r <= urg_s1_r;
    end
  end

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_elig
      wire paced_ok = (pmap_r[g] == '0) || pace_s2_r[pmap_r[g]];
      assign elig[g] = chan_enable[g] && active_r[g] && !pause_r[g] && (fetch_r[g] || paced_ok);
    end
  endgenerate

  // Round robin keeps one busy channel from starving the rest
  always_comb begin
    logic [3:0] idx;
    idx = '0;
    pick = last_r;
    any_elig = 1'b0;
    for (int i = 1; i <= NCH; i++) begin
      idx = last_r + 4'(i);
      if (!any_elig && elig[idx]) begin
        pick = idx;
        any_elig = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Current transfer
  // ----------------------------------------
  wire [4:0] cur_map = pmap_r[cur_r];
  wire pace_ok = (cur_map == '0) || pace_s2_r[cur_map];
  wire urgent = (cur_map != '0) && pace_s2_r[cur_map] && urg_s2_r[cur_map];
  wire [31:0] cur_cnt = cnt_r[cur_r];
  wire [31:0] cur_info = info_r[cur_r];
  wire prefetch = cur_info[INFO_PREFETCH];
  wire wide_wr = cur_info[INFO_WIDE_WR];
  wire [32:0] words_left = ({1'b0, cur_cnt} + 33'h0_0000_0003) >> 2;
  wire [4:0] burst = {1'b0, cur_info[INFO_BURST_LSB +: 4]} + 5'h01;
  wire [4:0] beats_now = (words_left < 33'(burst)) ? words_left[4:0] : burst;
  wire last_word = cur_cnt <= WORD_BYTES;
  wire [31:0] dec = last_word ? cur_cnt : WORD_BYTES;
  wire [3:0] strb = last_word ? (4'hf >> (3'h4 - 3'(cur_cnt))) : 4'hf;
  wire [4:0] beats_rem = nb_r - sent_r;

  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [31:0] f_out_data;
  wire f_in_valid = (st_r == ST_XDAT) && rdat_valid;
  wire take_fetch = (st_r == ST_FDAT) && rdat_valid;
  wire take_data = f_in_valid && f_in_ready;
  wire wr_go = (st_r == ST_XWR) && f_out_valid && pace_ok;
  assign f_out_ready = wr_go && (prefetch || mwr_ready);
  wire wr_fin = f_out_ready && (sent_r == nb_r - 5'h01);

  ldma_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(rdat_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // ----------------------------------------
  // Bus requests
  // ----------------------------------------
  assign mrd_valid = (st_r == ST_FREQ) || ((st_r == ST_XRD) && cur_cnt != '0 && pace_ok);
  assign mrd_req.addr = (st_r == ST_FREQ) ? desc_r[cur_r] : src_r[cur_r];
  assign mrd_req.beats = (st_r == ST_FREQ) ? DESC_BEATS : beats_now;
  assign mrd_req.prio = urgent;
  assign rdat_ready = (st_r == ST_FDAT) || ((st_r == ST_XDAT) && f_in_ready);
  assign mwr_valid = wr_go && !prefetch;
  assign mwr_req.addr = dst_r[cur_r];
  assign mwr_req.data = f_out_data;
  assign mwr_req.strb = strb;
  // Pairs only wide, whole beats; lone tails go out singly
  assign mwr_req.pair = pair_r || (wide_wr && beats_rem >= 5'h02);
  assign mwr_req.last = pair_r || !(wide_wr && beats_rem >= 5'h02);
  assign mwr_req.prio = urgent;
  assign bus_id = cur_info[INFO_BUS_LSB +: 2];
  assign sw_rd_view = view_r;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (any_elig) begin
          st_nxt = fetch_r[pick] ? ST_FREQ : ST_XRD;
        end
      end
      ST_FREQ: begin
        if (mrd_ready) begin
          st_nxt = ST_FDAT;
        end
      end
      ST_FDAT: begin
        if (take_fetch && beat_r == W_LAST) begin
          st_nxt = ST_XRD;
        end
      end
      ST_XRD: begin
        if (cur_cnt == '0) begin
          st_nxt = ST_DONE;
        end else if (mrd_valid && mrd_ready) begin
          st_nxt = ST_XDAT;
        end
      end
      ST_XDAT: begin
        if (take_data && got_r == nb_r - 5'h01) begin
          st_nxt = ST_XWR;
        end
      end
      ST_XWR: begin
        if (wr_fin) begin
          st_nxt = (cur_cnt == dec) ? ST_DONE : ST_IDLE;
        end
      end
      ST_DONE: begin
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      cur_r <= '0;
      last_r <= LAST_CH;
      beat_r <= '0;
      nb_r <= '0;
      got_r <= '0;
      sent_r <= '0;
      pair_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (st_r == ST_IDLE && any_elig) begin
        cur_r <= pick;
        last_r <= pick;
      end
      beat_r <= (st_r == ST_FDAT) ? beat_r + 3'(take_fetch) : '0;
      if (st_r == ST_XRD) begin
        nb_r <= beats_now;
      end
      got_r <= (st_r == ST_XDAT) ? got_r + 5'(take_data) : '0;
      sent_r <= (st_r == ST_XWR) ? sent_r + 5'(f_out_ready) : '0;
      if (f_out_ready) begin
        pair_r <= mwr_req.pair && !mwr_req.last;
      end
    end
  end

  // ----------------------------------------
  // Channel registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_r <= '0;
      pause_r <= '0;
      fetch_r <= '0;
      for (int i = 0; i < NCH; i++) begin
        desc_r[i] <= '0;
        info_r[i] <= '0;
        src_r[i] <= '0;
        aux_r[i] <= '0;
        dst_r[i] <= '0;
        step_r[i] <= '0;
        cnt_r[i] <= '0;
        next_r[i] <= '0;
        pmap_r[i] <= '0;
      end
    end else begin
      if (take_fetch) begin
        // Descriptor words land through fetches; software can also write next_r through SEL_NEXT
        case (beat_r)
          W_INFO: info_r[cur_r] <= rdat_data;
          W_SRC: src_r[cur_r] <= rdat_data;
          W_DST: begin
            if (is_wide(cur_r)) begin
              aux_r[cur_r] <= rdat_data;
            end else begin
              dst_r[cur_r] <= rdat_data;
            end
          end
          W_CNT: begin
            if (is_wide(cur_r)) begin
              dst_r[cur_r] <= rdat_data;
            end else begin
              cnt_r[cur_r] <= rdat_data;
            end
          end
          W_STEP: begin
            // Reduced channels have no step; word is ignored
            if (!is_lite(cur_r)) begin
              step_r[cur_r] <= rdat_data;
            end
          end
          W_NEXT: begin
            if (is_wide(cur_r)) begin
              cnt_r[cur_r] <= rdat_data;
            end else begin
              next_r[cur_r] <= rdat_data;
            end
          end
          WW_NEXT: begin
            if (is_wide(cur_r)) begin
              next_r[cur_r] <= rdat_data;
            end
          end
          default: begin
          end
        endcase
        if (beat_r == W_LAST) begin
          fetch_r[cur_r] <= 1'b0;
        end
      end
      if (st_r == ST_XRD && mrd_valid && mrd_ready) begin
        src_r[cur_r] <= src_r[cur_r] + (32'(beats_now) << 2);
      end
      if (f_out_ready) begin
        dst_r[cur_r] <= dst_r[cur_r] + WORD_BYTES;
        cnt_r[cur_r] <= cur_cnt - dec;
      end
      if (st_r == ST_DONE) begin
        desc_r[cur_r] <= next_r[cur_r];
        if (next_r[cur_r] == NULL_PTR) begin
          active_r[cur_r] <= 1'b0;
        end else begin
          fetch_r[cur_r] <= 1'b1;
        end
      end
      // Software last, so its activate wins over a stop
      if (sw_wr_en) begin
        case (sw_wr_sel)
          SEL_DESC: desc_r[sw_wr_chan] <= sw_wr_data;
          SEL_CTRL: begin
            active_r[sw_wr_chan] <= sw_wr_data[CTRL_ACTIVE];
            pause_r[sw_wr_chan] <= sw_wr_data[CTRL_PAUSE];
            if (sw_wr_data[CTRL_ACTIVE] && !active_r[sw_wr_chan]) begin
              fetch_r[sw_wr_chan] <= 1'b1;
            end
          end
          SEL_NEXT: next_r[sw_wr_chan] <= sw_wr_data;
          SEL_PACE: pmap_r[sw_wr_chan] <= sw_wr_data[4:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Read view
  // ----------------------------------------
  wire [31:0] rd_base = (sw_rd_chan == LAST_CH) ? LAST_CH_BASE : CH_BASE + CH_SPACING * 32'(sw_rd_chan);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      view_r <= '0;
    end else begin
      view_r <= '{rd_base, desc_r[sw_rd_chan], info_r[sw_rd_chan], src_r[sw_rd_chan], aux_r[sw_rd_chan],
                  dst_r[sw_rd_chan], step_r[sw_rd_chan], cnt_r[sw_rd_chan], next_r[sw_rd_chan],
                  active_r[sw_rd_chan], pause_r[sw_rd_chan]};
    end
  end
endmodule : ldma_top

// File: tb/ldma_checker.sv
// Port assertions for the linked descriptor DMA engine
`timescale 1ns/1ps
// ----------------------------------------
// Checker
// ----------------------------------------
module ldma_checker import ldma_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic sw_wr_en,
  input wire ldma_sel_e sw_wr_sel,
  input wire logic [31:0] sw_wr_data,
  input wire logic [3:0] sw_rd_chan,
  input wire ldma_view_s sw_rd_view,
  input wire logic [NPACE-1:0] urgent_pin,
  input wire logic mrd_valid,
  input wire ldma_rd_req_s mrd_req,
  input wire logic mrd_ready,
  input wire logic rdat_valid,
  input wire logic rdat_ready,
  input wire logic mwr_valid,
  input wire ldma_wr_req_s mwr_req,
  input wire logic mwr_ready
);
  logic [4:0] pend_r;
  logic act_r;
  logic urg_r;
  logic up_r;
  logic [3:0] chan_q_r;
  logic [31:0] base_exp;
  // Beats still owed on the read channel; only one read may be open
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= 5'h00;
      act_r <= 1'h0;
      urg_r <= 1'h0;
      up_r <= 1'h0;
      chan_q_r <= 4'h0;
    end else begin
      if (mrd_valid && mrd_ready) begin
        pend_r <= mrd_req.beats;
      end else if (rdat_valid && rdat_ready) begin
        pend_r <= pend_r - 5'h01;
      end
      act_r <= act_r || (sw_wr_en && sw_wr_sel == SEL_CTRL && sw_wr_data[CTRL_ACTIVE]);
      urg_r <= urg_r || (|urgent_pin);
      up_r <= 1'h1;
      chan_q_r <= sw_rd_chan;
    end
  end
  assign base_exp = (chan_q_r == LAST_CH) ? LAST_CH_BASE : CH_BASE + CH_SPACING * 32'(chan_q_r);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_idle_no_req: assert property (!act_r |-> !mrd_valid && !mwr_valid)
    else $error("bus request before any activation");
  a_wr_hold: assert property (mwr_valid && !mwr_ready |=> mwr_valid && $stable(mwr_req))
    else $error("write request changed before taken");
  a_wr_single_last: assert property (mwr_valid && !mwr_req.pair |-> mwr_req.last)
    else $error("single write not marked last");
  a_one_read: assert property (mrd_valid |-> pend_r == 5'h00)
    else $error("read issued with beats outstanding");
  a_wr_after_data: assert property (mwr_valid |-> pend_r == 5'h00 && !mrd_valid)
    else $error("write before burst data arrived");
  // Stable viewed channel and no software write, so only the engine could stop it
  a_stop_clears: assert property ($fell(sw_rd_view.active) && $past(chan_q_r) == chan_q_r
    && !$past(sw_wr_en) && !$past(sw_wr_en, 2) |-> sw_rd_view.desc_addr == NULL_PTR)
    else $error("stopped channel kept descriptor address");
  a_prio_cause: assert property (mrd_valid && mrd_req.prio |-> urg_r)
    else $error("priority raised without urgency");
  a_base_map: assert property (up_r |-> sw_rd_view.base == base_exp)
    else $error("channel base address wrong");
  c_desc_fetch: cover property (mrd_valid && mrd_ready && mrd_req.beats == DESC_BEATS);
  c_pair_write: cover property (mwr_valid && mwr_ready && mwr_req.pair);
  c_stop: cover property ($fell(sw_rd_view.active));
endmodule : ldma_checker

bind ldma_top ldma_checker i_ldma_checker (.clk(clk), .rst(rst), .sw_wr_en(sw_wr_en),
  .sw_wr_sel(sw_wr_sel), .sw_wr_data(sw_wr_data), .sw_rd_chan(sw_rd_chan),
  .sw_rd_view(sw_rd_view), .urgent_pin(urgent_pin), .mrd_valid(mrd_valid),
  .mrd_req(mrd_req), .mrd_ready(mrd_ready), .rdat_valid(rdat_valid),
  .rdat_ready(rdat_ready), .mwr_valid(mwr_valid), .mwr_req(mwr_req), .mwr_ready(mwr_ready));

// File: tb/ldma_mem.sv
// Memory model answering the engine's read bursts and writes
`timescale 1ns/1ps
// ----------------------------------------
// Memory
// ----------------------------------------
module ldma_mem import ldma_pkg::*; (
  input wire logic clk,
  input wire logic slow,
  input wire logic mrd_valid,
  input wire ldma_rd_req_s mrd_req,
  output logic mrd_ready,
  output logic rdat_valid,
  output logic [31:0] rdat_data,
  input wire logic rdat_ready,
  input wire logic mwr_valid,
  input wire ldma_wr_req_s mwr_req,
  output logic mwr_ready
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] ra;
  logic [4:0] left;
  logic ph;
  function automatic logic [31:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 32'h0000_0000;
  endfunction : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] w;
    w = rd(a);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        w[8*b +: 8] = d[8*b +: 8];
      end
    end
    mem[a] = w;
  endtask : wr
  // Slow mode answers only every other cycle to stretch every handshake
  initial begin
    mrd_ready = 1'h0;
    rdat_valid = 1'h0;
    rdat_data = 32'h0000_0000;
    mwr_ready = 1'h0;
    left = 5'h00;
    ra = 32'h0000_0000;
    ph = 1'h0;
    forever begin
      @(posedge clk);
      if (mwr_valid && mwr_ready) begin
        wr(mwr_req.addr, mwr_req.data, mwr_req.strb);
      end
      if (mrd_valid && mrd_ready) begin
        ra = mrd_req.addr;
        left = mrd_req.beats;
      end
      if (rdat_valid && rdat_ready) begin
        ra = ra + 32'h0000_0004;
        left = left - 5'h01;
      end
      #1;
      ph = !ph;
      mrd_ready = left == 5'h00 && (ph || !slow);
      rdat_valid = left != 5'h00 && (ph || !slow);
      // Idle data is inverted so a stale word is never mistaken for a beat
      rdat_data = rdat_valid ? rd(ra) : ~rdat_data;
      mwr_ready = ph || !slow;
    end
  end
endmodule : ldma_mem

// File: tb/test_linked_descriptor_dma.sv
// Self-checking testbench for the linked descriptor DMA engine
`timescale 1ns/1ps
module test_linked_descriptor_dma import ldma_pkg::*; ();
  localparam logic [31:0] INFO = 32'h0000_3000;
  localparam logic [31:0] SRC = 32'h0000_4000;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [NCH-1:0] chan_enable = 16'hffff;
  logic sw_wr_en = 1'h0;
  ldma_sel_e sw_wr_sel = SEL_DESC;
  logic [3:0] sw_wr_chan = 4'h0;
  logic [31:0] sw_wr_data = 32'h0000_0000;
  logic [3:0] sw_rd_chan = 4'h0;
  ldma_view_s sw_rd_view;
  logic [NPACE-1:0] pace_req_pin = 32'h0000_0000;
  logic [NPACE-1:0] urgent_pin = 32'h0000_0000;
  logic mrd_valid, mrd_ready, rdat_valid, rdat_ready, mwr_valid, mwr_ready;
  ldma_rd_req_s mrd_req;
  ldma_wr_req_s mwr_req;
  logic [31:0] rdat_data;
  logic [1:0] bus_id;
  logic slow = 1'h0;
  logic seen_prio = 1'h0;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  ldma_top i_ldma_top (.clk(clk), .rst(rst), .chan_enable(chan_enable), .sw_wr_en(sw_wr_en),
    .sw_wr_sel(sw_wr_sel), .sw_wr_chan(sw_wr_chan), .sw_wr_data(sw_wr_data),
    .sw_rd_chan(sw_rd_chan), .sw_rd_view(sw_rd_view), .pace_req_pin(pace_req_pin),
    .urgent_pin(urgent_pin), .mrd_valid(mrd_valid), .mrd_req(mrd_req), .mrd_ready(mrd_ready),
    .rdat_valid(rdat_valid), .rdat_data(rdat_data), .rdat_ready(rdat_ready),
    .mwr_valid(mwr_valid), .mwr_req(mwr_req), .mwr_ready(mwr_ready), .bus_id(bus_id));
  ldma_mem i_ldma_mem (.clk(clk), .slow(slow), .mrd_valid(mrd_valid), .mrd_req(mrd_req),
    .mrd_ready(mrd_ready), .rdat_valid(rdat_valid), .rdat_data(rdat_data),
    .rdat_ready(rdat_ready), .mwr_valid(mwr_valid), .mwr_req(mwr_req), .mwr_ready(mwr_ready));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task tally_and_finish;
    $display("errors %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cycles++;
    if ((mrd_valid && mrd_req.prio) === 1'h1) begin
      seen_prio <= 1'h1;
    end
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input ldma_sel_e s, input logic [3:0] c, input logic [31:0] d);
    @(posedge clk);
    #1;
    sw_wr_en = 1'h1;
    sw_wr_sel = s;
    sw_wr_chan = c;
    sw_wr_data = d;
    @(posedge clk);
    #1;
    sw_wr_en = 1'h0;
  endtask : wr
  task view(input logic [3:0] c);
    @(posedge clk);
    #1;
    sw_rd_chan = c;
    repeat (2) @(posedge clk);
    #1;
  endtask : view
  task put(input logic [31:0] a, input logic [31:0] w [8]);
    for (int i = 0; i < 8; i++) begin
      i_ldma_mem.mem[a + 32'(4 * i)] = w[i];
    end
  endtask : put
  task go(input logic [3:0] c, input logic [31:0] a);
    wr(SEL_DESC, c, a);
    wr(SEL_CTRL, c, 32'h0000_0001);
  endtask : go
  task wait_done(input logic [3:0] c);
    int n;
    view(c);
    n = 0;
    while (sw_rd_view.active !== 1'h0 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp({31'h0000_0000, sw_rd_view.active}, 32'h0000_0000);
    cmp(sw_rd_view.desc_addr, NULL_PTR);
    cmp(sw_rd_view.count, 32'h0000_0000);
  endtask : wait_done
  task chk(input logic [31:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      cmp(i_ldma_mem.rd(d + 32'(4 * i)), 32'ha5a5_0000 + 32'(i));
    end
    cmp(i_ldma_mem.rd(d + 32'(4 * n)), 32'h0000_0000);
  endtask : chk
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_views;
    for (int c = 0; c < NCH; c++) begin
      view(4'(c));
      cmp(sw_rd_view.base, c == NCH - 1 ? LAST_CH_BASE : CH_BASE + CH_SPACING * 32'(c));
      cmp({31'h0000_0000, sw_rd_view.active}, 32'h0000_0000);
    end
  endtask : t_views
  // One descriptor per layout; the wide layout moves dst and next down a word and count down two
  task t_kind(input logic [3:0] c);
    logic [31:0] d;
    d = 32'h0000_8000 + {20'h0_0000, c, 8'h00};
    if (c >= WIDE_FIRST && c <= WIDE_LAST) begin
      put(32'h0000_2000, '{INFO, SRC, 32'h0000_0011, d, 32'h0000_0022, 32'h0000_0010, 0, 0});
    end else begin
      put(32'h0000_2000, '{INFO, SRC, d, 32'h0000_0010, 0, 0, 0, 0});
    end
    go(c, 32'h0000_2000);
    wait_done(c);
    cmp(sw_rd_view.info, INFO);
    if (c >= WIDE_FIRST && c <= WIDE_LAST) begin
      cmp(sw_rd_view.aux, 32'h0000_0011);
      cmp(sw_rd_view.step, 32'h0000_0022);
    end
    chk(d, 4);
  endtask : t_kind
  task t_chain;
    put(32'h0000_1000, '{INFO, SRC, 32'h0000_9000, 32'h0000_0010, 0, 32'h0000_1020, 0, 0});
    put(32'h0000_1020, '{INFO | 32'h0000_0020, SRC, 32'h0000_9100, 32'h0000_000c, 0, 0, 0, 0});
    go(4'h3, 32'h0000_1000);
    wait_done(4'h3);
    cmp(sw_rd_view.info, INFO | 32'h0000_0020);
    chk(32'h0000_9000, 4);
    chk(32'h0000_9100, 3);
  endtask : t_chain
  task t_pace;
    wr(SEL_PACE, 4'h1, 32'h0000_0005);
    put(32'h0000_3000, '{INFO | 32'h1000_0000, SRC, 32'h0000_9800, 32'h0000_0010, 0, 0, 0, 0});
    put(32'h0000_3040, '{INFO, SRC, 32'h0000_9c00, 32'h0000_0008, 0, 0, 0, 0});
    go(4'h1, 32'h0000_3000);
    repeat (60) @(posedge clk);
    cmp(i_ldma_mem.rd(32'h0000_9800), 32'h0000_0000);
    cmp({31'h0000_0000, seen_prio}, 32'h0000_0000);
    #1;
    cmp({30'h0000_0000, bus_id}, 32'h0000_0002);
    // Stalled on pacing: pause, splice a second descriptor in, resume
    wr(SEL_CTRL, 4'h1, 32'h0000_0003);
    view(4'h1);
    cmp({31'h0000_0000, sw_rd_view.paused}, 32'h0000_0001);
    wr(SEL_NEXT, 4'h1, 32'h0000_3040);
    wr(SEL_CTRL, 4'h1, 32'h0000_0001);
    pace_req_pin[5] = 1'h1;
    urgent_pin[5] = 1'h1;
    wait_done(4'h1);
    chk(32'h0000_9800, 4);
    chk(32'h0000_9c00, 2);
    cmp({31'h0000_0000, seen_prio}, 32'h0000_0001);
  endtask : t_pace
  task t_enable;
    put(32'h0000_3060, '{INFO, SRC, 32'h0000_9e00, 32'h0000_0010, 0, 0, 0, 0});
    chan_enable[5] = 1'h0;
    go(4'h5, 32'h0000_3060);
    repeat (40) @(posedge clk);
    #1;
    cmp(i_ldma_mem.rd(32'h0000_9e00), 32'h0000_0000);
    view(4'h5);
    cmp({31'h0000_0000, sw_rd_view.active}, 32'h0000_0001);
    chan_enable[5] = 1'h1;
    wait_done(4'h5);
    chk(32'h0000_9e00, 4);
  endtask : t_enable
  task t_prefetch;
    put(32'h0000_3020, '{INFO | 32'h0400_0000, SRC, 32'h0000_9a00, 32'h0000_0010, 0, 0, 0, 0});
    go(4'h2, 32'h0000_3020);
    wait_done(4'h2);
    cmp(i_ldma_mem.rd(32'h0000_9a00), 32'h0000_0000);
  endtask : t_prefetch
  initial begin
    for (int k = 0; k < 16; k++) begin
      i_ldma_mem.mem[SRC + 32'(4 * k)] = 32'ha5a5_0000 + 32'(k);
    end
    repeat (6) @(posedge clk);
    #1;
    rst = 1'h0;
    t_views();
    t_kind(4'h0);
    t_kind(4'h7);
    t_kind(4'hb);
    slow = 1'h1;
    t_chain();
    slow = 1'h0;
    t_pace();
    t_prefetch();
    t_enable();
    tally_and_finish();
  end
endmodule : test_linked_descriptor_dma
